// ==== design/spindle_cmd_regs.vh ====
// Register offsets, field positions and reset values for the spindle command decoder.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef SPINDLE_CMD_REGS_VH
`define SPINDLE_CMD_REGS_VH

// ==========================================================
// Register byte offsets
`define OFS_CTRL_A      12'h000
`define OFS_CTRL_B      12'h004
`define OFS_POS_A       12'h008
`define OFS_POS_B       12'h00C
`define OFS_STAT_A      12'h010
`define OFS_STAT_B      12'h014
`define OFS_SYNC        12'h018
`define OFS_ID          12'h01C

// ==========================================================
// Control word fields (one per spindle)
`define B_RANGE_SEL     0
`define B_LINE_CHECK    1
`define B_STOP_CHANGE   2
`define B_CHANGE_DIR    3
`define B_SHORT_MOVE    4
`define B_DIFF_MODE     5
`define B_OVERRIDE_EN   6
`define B_INCR_ORIENT   7
`define B_MAIN_CONT     8
`define B_HIGH_CONT     9
`define B_MAG_ORIENT    10
`define B_SLAVE_OP      11
`define B_POWER_OFF     12
`define B_WIRE_DIS      13
`define B_HALT_N        14
`define B_ORIENT_RUN    15
`define CTRL_BITS       16

// Sync word fields (shared)
`define B_SPEED_SYNC    0
`define B_PHASE_SYNC    1
`define B_RIGID_TAP     2
`define B_FUNC_DONE     3

// Status word fields
`define S_SPEED_REACHED 0
`define S_MOVE_BUSY     1
`define S_MOVE_DIR      2
`define S_CAPTURED      3
`define S_POWER_OFF     4
`define S_HALTED        5

// ==========================================================
// Reset values, ID word, half-turn and position mask constants
`define CTRL_RESET      16'h4000
`define POS_RESET       12'h000
`define SYNC_RESET      4'h0
`define ID_VALUE        32'h0000A5C3
`define HALF_TURN       12'h800
`define POS_MASK        12'hFFF

`endif

// ==== design/spindle_command_decoder.v ====
// Spindle command decoder for two spindles, register-driven over APB.
// Assumes a single 100 MHz clock, synchronous active-high reset, and
// external speed, position and velocity values supplied as plain inputs.
//
// Behaviour
// RL1: range request 0 high, 1 low characteristic
// RL2: line check 0 high, 1 low wiring
// RL3: falling stop-change edge captures, moves, halts
// RL4: direction 0 counterclockwise, 1 clockwise
// RL5: short move takes shortest path, half turn
// RL6: differential mode while bit set
// RL7: analog override only while enable set
// RL8: incremental orientation when bit set
// RL9: main contactor closed when bit set
// RL10: high-speed contactor closed when bit set
// RL11: magnetic sensor orientation when bit set
// RL12: slave operation follows slave bit
// RL13: motor power removed while stop bit set
// RL14: detection suppressed while disable bit set
// RL15: halt low forces zero velocity command
// RL16: speed reached once actual meets command
// RL17: controller sets function done when finished
// RL18: orientation in progress outputs parameter velocity
// RL19: speed sync runs while bit set
// RL20: phase sync runs while bit set
// RL21: rigid tapping runs while bit set
// RL22: twelve-bit stop position per spindle
// RL23: edge inputs keep previous level once
`include "spindle_cmd_regs.vh"

module spindle_command_decoder (
    input  wire        mclk,
    input  wire        reset,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [11:0] actual_pos_a,
    input  wire [11:0] actual_pos_b,
    input  wire [15:0] actual_speed_a,
    input  wire [15:0] actual_speed_b,
    input  wire [15:0] cmd_speed_a,
    input  wire [15:0] cmd_speed_b,
    input  wire [15:0] orient_velocity,
    output reg  [1:0]  low_range_sel,
    output reg  [1:0]  low_range_wired,
    output reg  [1:0]  differential_mode,
    output reg  [1:0]  analog_override_en,
    output reg  [1:0]  incremental_orient,
    output reg  [1:0]  main_contactor_state,
    output reg  [1:0]  high_range_contactor_state,
    output reg  [1:0]  magnetic_orient_cmd,
    output reg  [1:0]  slave_operation,
    output reg  [1:0]  motor_power_off,
    output reg  [1:0]  wire_check_enable,
    output reg  [1:0]  move_active,
    output reg  [1:0]  move_clockwise,
    output reg  [23:0] orient_stop_position,
    output reg  [31:0] velocity_cmd,
    output reg  [1:0]  speed_reached,
    output reg         speed_sync_cmd,
    output reg         phase_sync_cmd,
    output reg         rigid_tap_cmd,
    output reg         function_done
);

    // ==========================================================
    // Register file
    reg  [15:0] ctrl_reg [0:1];
    reg  [11:0] pos_reg  [0:1];
    reg  [3:0]  sync_reg;
    reg  [1:0]  stop_prev_reg;
    reg  [1:0]  captured_reg;
    reg  [1:0]  move_busy_reg;
    reg  [1:0]  move_dir_reg;
    reg  [11:0] target_reg [0:1];

    wire        wr_en   = psel & penable & pwrite;
    wire        rd_en   = psel & penable & ~pwrite;

    // Zero wait states; unmapped offsets answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_known(paddr);

    // Address decode used by the error answer; the read mux decodes paddr with its own case
    function addr_known;
        input [11:0] a;
        begin
            addr_known = (a == `OFS_CTRL_A) || (a == `OFS_CTRL_B) ||
                         (a == `OFS_POS_A)  || (a == `OFS_POS_B)  ||
                         (a == `OFS_STAT_A) || (a == `OFS_STAT_B) ||
                         (a == `OFS_SYNC)   || (a == `OFS_ID);
        end
    endfunction

    // Shortest-path direction: forward distance under half a turn goes clockwise
    function short_dir_cw;
        input [11:0] from_pos;
        input [11:0] to_pos;
        reg   [11:0] fwd;
        begin
            fwd          = to_pos - from_pos;
            short_dir_cw = (fwd < `HALF_TURN); // see RL5
        end
    endfunction

    // ==========================================================
    // Shared sync and completion bits
    always @(posedge mclk) begin
        if (reset) begin
            sync_reg <= `SYNC_RESET;
        end else if (wr_en && paddr == `OFS_SYNC) begin
            sync_reg <= pwdata[3:0];
        end
    end

    // ==========================================================
    // Per-spindle control, edge capture and stop-position move
    genvar s;
    generate
        for (s = 0; s < 2; s = s + 1) begin : spindle
            wire [11:0] ofs_ctrl  = (s == 0) ? `OFS_CTRL_A : `OFS_CTRL_B;
            wire [11:0] ofs_pos   = (s == 0) ? `OFS_POS_A  : `OFS_POS_B;
            wire [11:0] act_pos   = (s == 0) ? actual_pos_a   : actual_pos_b;
            wire [15:0] act_spd   = (s == 0) ? actual_speed_a : actual_speed_b;
            wire [15:0] cmd_spd   = (s == 0) ? cmd_speed_a    : cmd_speed_b;
            wire        stop_bit  = ctrl_reg[s][`B_STOP_CHANGE];
            // Falling edge of the stop-change bit; previous level kept once
            wire        stop_fall = stop_prev_reg[s] & ~stop_bit; // see RL23

            // Control and position registers written by software
            always @(posedge mclk) begin
                if (reset) begin
                    ctrl_reg[s] <= `CTRL_RESET;
                    pos_reg[s]  <= `POS_RESET;
                end else begin
                    if (wr_en && paddr == ofs_ctrl)
                        ctrl_reg[s] <= pwdata[15:0];
                    if (wr_en && paddr == ofs_pos)
                        pos_reg[s] <= pwdata[11:0]; // see RL22
                end
            end

            // Edge history, capture and move sequencing
            always @(posedge mclk) begin
                if (reset) begin
                    stop_prev_reg[s] <= 1'b0;
                    captured_reg[s]  <= 1'b0;
                    move_busy_reg[s] <= 1'b0;
                    move_dir_reg[s]  <= 1'b0;
                    target_reg[s]    <= `POS_RESET;
                end else begin
                    stop_prev_reg[s] <= stop_bit; // see RL23
                    if (stop_fall) begin
                        // New target taken only at the 1-to-0 transition
                        target_reg[s]    <= pos_reg[s]; // see RL3
                        captured_reg[s]  <= 1'b1;
                        move_busy_reg[s] <= (pos_reg[s] != act_pos);
                        if (ctrl_reg[s][`B_SHORT_MOVE])
                            move_dir_reg[s] <= short_dir_cw(act_pos, pos_reg[s]); // see RL5
                        else
                            move_dir_reg[s] <= ctrl_reg[s][`B_CHANGE_DIR]; // see RL4
                    end else if (move_busy_reg[s] && act_pos == target_reg[s]) begin
                        // Spindle reached the new stop position and halts
                        move_busy_reg[s] <= 1'b0; // see RL3
                    end
                end
            end

            // Decoded mode outputs, all registered
            always @(posedge mclk) begin
                if (reset) begin
                    low_range_sel[s]              <= 1'b0;
                    low_range_wired[s]            <= 1'b0;
                    differential_mode[s]          <= 1'b0;
                    analog_override_en[s]         <= 1'b0;
                    incremental_orient[s]         <= 1'b0;
                    main_contactor_state[s]       <= 1'b0;
                    high_range_contactor_state[s] <= 1'b0;
                    magnetic_orient_cmd[s]        <= 1'b0;
                    slave_operation[s]            <= 1'b0;
                    motor_power_off[s]            <= 1'b0;
                    wire_check_enable[s]          <= 1'b1;
                    move_active[s]                <= 1'b0;
                    move_clockwise[s]             <= 1'b0;
                    speed_reached[s]              <= 1'b0;
                    orient_stop_position[s*12 +: 12] <= `POS_RESET;
                    velocity_cmd[s*16 +: 16]      <= 16'h0000;
                end else begin
                    low_range_sel[s]        <= ctrl_reg[s][`B_RANGE_SEL];  // see RL1
                    low_range_wired[s]      <= ctrl_reg[s][`B_LINE_CHECK]; // see RL2
                    differential_mode[s]    <= ctrl_reg[s][`B_DIFF_MODE];  // see RL6
                    analog_override_en[s]   <= ctrl_reg[s][`B_OVERRIDE_EN]; // see RL7
                    incremental_orient[s]   <= ctrl_reg[s][`B_INCR_ORIENT]; // see RL8
                    main_contactor_state[s] <= ctrl_reg[s][`B_MAIN_CONT];  // see RL9
                    high_range_contactor_state[s] <= ctrl_reg[s][`B_HIGH_CONT]; // see RL10
                    magnetic_orient_cmd[s]  <= ctrl_reg[s][`B_MAG_ORIENT]; // see RL11
                    slave_operation[s]      <= ctrl_reg[s][`B_SLAVE_OP];   // see RL12
                    motor_power_off[s]      <= ctrl_reg[s][`B_POWER_OFF];  // see RL13
                    wire_check_enable[s]    <= ~ctrl_reg[s][`B_WIRE_DIS];  // see RL14
                    move_active[s]          <= move_busy_reg[s];
                    move_clockwise[s]       <= move_dir_reg[s];            // see RL4
                    speed_reached[s]        <= (act_spd == cmd_spd);       // see RL16
                    orient_stop_position[s*12 +: 12] <= target_reg[s];     // see RL22
                    // Halt beats orientation: a stopped spindle must never creep
                    if (!ctrl_reg[s][`B_HALT_N] || ctrl_reg[s][`B_POWER_OFF])
                        velocity_cmd[s*16 +: 16] <= 16'h0000;              // see RL15
                    else if (ctrl_reg[s][`B_ORIENT_RUN])
                        velocity_cmd[s*16 +: 16] <= orient_velocity;       // see RL18
                    else
                        velocity_cmd[s*16 +: 16] <= cmd_spd;               // see RL15
                end
            end
        end
    endgenerate

    // ==========================================================
    // Shared command outputs
    always @(posedge mclk) begin
        if (reset) begin
            speed_sync_cmd <= 1'b0;
            phase_sync_cmd <= 1'b0;
            rigid_tap_cmd  <= 1'b0;
            function_done  <= 1'b0;
        end else begin
            speed_sync_cmd <= sync_reg[`B_SPEED_SYNC]; // see RL19
            phase_sync_cmd <= sync_reg[`B_PHASE_SYNC]; // see RL20
            rigid_tap_cmd  <= sync_reg[`B_RIGID_TAP];  // see RL21
            function_done  <= sync_reg[`B_FUNC_DONE];  // see RL17
        end
    end

    // ==========================================================
    // Read mux; status words show live move and reach state
    always @* begin
        prdata = 32'h00000000;
        if (rd_en) begin
            case (paddr)
                `OFS_CTRL_A: prdata = {16'h0000, ctrl_reg[0]};
                `OFS_CTRL_B: prdata = {16'h0000, ctrl_reg[1]};
                `OFS_POS_A:  prdata = {20'h00000, pos_reg[0]};
                `OFS_POS_B:  prdata = {20'h00000, pos_reg[1]};
                `OFS_STAT_A: prdata = {26'h0000000, ~ctrl_reg[0][`B_HALT_N],
                                       ctrl_reg[0][`B_POWER_OFF], captured_reg[0],
                                       move_dir_reg[0], move_busy_reg[0], speed_reached[0]};
                `OFS_STAT_B: prdata = {26'h0000000, ~ctrl_reg[1][`B_HALT_N],
                                       ctrl_reg[1][`B_POWER_OFF], captured_reg[1],
                                       move_dir_reg[1], move_busy_reg[1], speed_reached[1]};
                `OFS_SYNC:   prdata = {28'h0000000, sync_reg};
                `OFS_ID:     prdata = `ID_VALUE; // arbitrary value
                default:     prdata = 32'h00000000;
            endcase
        end
    end

endmodule // spindle_command_decoder

// ==== verif/spindle_decoder_sva.sv ====
// Port-level checks of the spindle command decoder.
// Assumes the shared register header and the designer's two-edge output delay.
`include "spindle_cmd_regs.vh"
module spindle_decoder_sva (
    input wire        mclk, reset, psel, penable, pwrite, pslverr,
    input wire [11:0] paddr,
    input wire [31:0] pwdata, prdata, velocity_cmd,
    input wire [15:0] actual_speed_a, cmd_speed_a,
    input wire [1:0]  low_range_sel, motor_power_off, wire_check_enable, speed_reached,
    input wire        speed_sync_cmd, phase_sync_cmd, rigid_tap_cmd
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // ============================================================
    // Write strobes; a stored word shows at the outputs one edge later
    wire acc  = psel && penable;
    wire wr_a = acc && pwrite && paddr == `OFS_CTRL_A;
    wire wr_b = acc && pwrite && paddr == `OFS_CTRL_B;
    wire wr_s = acc && pwrite && paddr == `OFS_SYNC;
    a_range_select:
    assert property (wr_a |-> ##2 low_range_sel[0] == $past(pwdata[0], 2))
        else $error("range select mismatch");
    a_power_stop:
    assert property (wr_b |-> ##2 motor_power_off[1] == $past(pwdata[12], 2))
        else $error("power stop mismatch");
    a_wire_check:
    assert property (wr_a |-> ##2 wire_check_enable[0] == !$past(pwdata[13], 2))
        else $error("wire check mismatch");
    a_halt_zero:
    assert property (wr_a && !pwdata[14] |-> ##2 velocity_cmd[15:0] == 16'h0000)
        else $error("halt left velocity");
    a_sync_modes:
    assert property (wr_s |-> ##2
        {rigid_tap_cmd, phase_sync_cmd, speed_sync_cmd} == $past(pwdata[2:0], 2))
        else $error("sync mode mismatch");
    // Speed reached is a registered compare, so it is skipped just after reset
    a_speed_reach:
    assert property (!$past(reset) |-> speed_reached[0] == $past(actual_speed_a == cmd_speed_a))
        else $error("speed reached mismatch");
    a_id_read:
    assert property (acc && !pwrite && paddr == `OFS_ID |-> prdata == `ID_VALUE && !pslverr)
        else $error("id read mismatch");
    a_unmapped_err:
    assert property (acc && paddr > 12'h01C |-> pslverr)
        else $error("unmapped access not refused");
    c_halt: cover property (wr_a && !pwdata[14]);
    c_done: cover property (wr_s && pwdata[3]);
    c_bad: cover property (acc && paddr > 12'h01C);
endmodule // spindle_decoder_sva
bind spindle_command_decoder spindle_decoder_sva chk (.*);

// ==== verif/plc_bus_master.sv ====
// Controller-side APB master that writes the spindle command words.
// Assumes it is called from the bench; it waits on pready with no fixed latency.
module plc_bus_master (
    input  wire         mclk, pready, pslverr,
    input  wire  [31:0] prdata,
    output logic        psel, penable, pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // ============================================================
    // One transfer; the function done bit is set only by this side
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        // Only the bench watchdog may end this wait
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00; // Released only after the answer edge
    endtask
endmodule // plc_bus_master

// ==== verif/spindle_command_decoder_tb.sv ====
// Self-checking bench for the spindle command decoder.
// Assumes the controller model drives APB; positions and speeds come from here.
`include "spindle_cmd_regs.vh"
module spindle_command_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, reset = 1'b1, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr, actual_pos_a, actual_pos_b;
    logic [31:0] pwdata, prdata, velocity_cmd, rd;
    logic [15:0] actual_speed_a, actual_speed_b, cmd_speed_a, cmd_speed_b, orient_velocity, w;
    logic [1:0]  low_range_sel, low_range_wired, differential_mode, analog_override_en,
                 incremental_orient, main_contactor_state, high_range_contactor_state,
                 magnetic_orient_cmd, slave_operation, motor_power_off, wire_check_enable,
                 move_active, move_clockwise, speed_reached;
    logic [23:0] orient_stop_position;
    logic        speed_sync_cmd, phase_sync_cmd, rigid_tap_cmd, function_done;
    int          num_errors = 0, check_count = 0;
    logic [11:0] ra [5] = '{`OFS_CTRL_A, `OFS_CTRL_B, `OFS_POS_A, `OFS_SYNC, `OFS_ID};
    logic [31:0] rv [5] = '{`CTRL_RESET, `CTRL_RESET, `POS_RESET, `SYNC_RESET, `ID_VALUE};
    logic [15:0] cw [5] = '{16'h0000, 16'hFFFB, 16'hC000, 16'h4000, 16'h5000};
    logic [15:0] mv [4] = '{16'h4018, 16'h4008, 16'h4000, 16'h4010};
    logic [11:0] tg [4] = '{12'h050, 12'h050, 12'h050, 12'h180};
    always #5 mclk = ~mclk;
    spindle_command_decoder DUT (.*);
    plc_bus_master plc (.*);
    // ============================================================
    // Compare and verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ============================================================
    // Expected behaviour; halt or power stop wins over the orientation speed
    function automatic logic [15:0] vel_exp(input logic [15:0] c, input logic [15:0] cmd);
        vel_exp = (!c[14] || c[12]) ? 16'h0000 : (c[15] ? orient_velocity : cmd);
    endfunction
    function automatic logic dir_exp(input logic [15:0] c, input logic [11:0] f, t);
        logic [11:0] fwd;
        fwd = t - f;
        dir_exp = c[4] ? (fwd < `HALF_TURN) : c[3];
    endfunction
    task automatic ctrl_check(input int i, input logic [15:0] c);
        plc.xfer(1'b1, i ? `OFS_CTRL_B : `OFS_CTRL_A, 32'(c), rd, err);
        repeat (2) @(negedge mclk);
        check(32'({low_range_sel[i], low_range_wired[i], differential_mode[i],
            analog_override_en[i], incremental_orient[i], main_contactor_state[i],
            high_range_contactor_state[i], magnetic_orient_cmd[i], slave_operation[i],
            motor_power_off[i], wire_check_enable[i]}), 32'({c[0], c[1], c[5], c[6], c[7], c[8],
            c[9], c[10], c[11], c[12], ~c[13]}));
        check(32'(velocity_cmd[16*i +: 16]),
              32'(vel_exp(c, i ? cmd_speed_b : cmd_speed_a)));
    endtask
    // ============================================================
    // Main sequence: reset values, decode, speed, sync modes, stop moves
    initial begin
        {actual_pos_a, actual_pos_b, actual_speed_a, actual_speed_b} = {12'h100, 44'h0};
        void'($urandom(29466));
        cmd_speed_a = 16'($urandom);
        cmd_speed_b = 16'($urandom);
        orient_velocity = 16'h1234;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        @(negedge mclk);
        check(32'(wire_check_enable), 32'h3);
        foreach (ra[k]) begin
            plc.xfer(1'b0, ra[k], 32'h0, rd, err);
            check(rd, rv[k]);
        end
        plc.xfer(1'b0, 12'h020, 32'h0, rd, err);
        check(32'(err), 32'h1);
        foreach (cw[k]) for (int i = 0; i < 2; i++) ctrl_check(i, cw[k]);
        for (int n = 0; n < 40; n++) ctrl_check(n % 2, 16'($urandom) & 16'hFFFB);
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            actual_speed_a <= cmd_speed_a + 16'(k);
            actual_speed_b <= cmd_speed_b + 16'(k);
            repeat (2) @(negedge mclk);
            check(32'(speed_reached), (k == 0) ? 32'h3 : 32'h0);
        end
        for (int v = 0; v < 16; v++) begin
            plc.xfer(1'b1, `OFS_SYNC, 32'(v), rd, err);
            repeat (2) @(negedge mclk);
            check(32'({function_done, rigid_tap_cmd, phase_sync_cmd, speed_sync_cmd}),
                  32'(v));
        end
        foreach (mv[k]) begin
            @(posedge mclk);
            actual_pos_a <= 12'h100;
            plc.xfer(1'b1, `OFS_POS_A, 32'(tg[k]), rd, err);
            plc.xfer(1'b1, `OFS_CTRL_A, 32'(mv[k] | 16'h0004), rd, err);
            plc.xfer(1'b1, `OFS_CTRL_A, 32'(mv[k]), rd, err);
            repeat (3) @(negedge mclk);
            check(32'({move_active[0], orient_stop_position[11:0]}), 32'({1'b1, tg[k]}));
            check(32'(move_clockwise[0]), 32'(dir_exp(mv[k], 12'h100, tg[k])));
            // Status word: not halted, power on, captured, direction, busy, speed not reached
            plc.xfer(1'b0, `OFS_STAT_A, 32'h0, rd, err);
            check(rd, 32'({mv[k][12], 1'b1, dir_exp(mv[k], 12'h100, tg[k]), 2'b10}));
            plc.xfer(1'b1, `OFS_POS_A, 32'h0, rd, err);
            plc.xfer(1'b1, `OFS_CTRL_A, 32'(mv[k]), rd, err);
            @(posedge mclk);
            actual_pos_a <= tg[k];
            repeat (4) @(negedge mclk);
            check(32'({move_active[0], orient_stop_position[11:0]}), 32'({1'b0, tg[k]}));
        end
        end_of_test;
    end
    // Hang guard, well beyond the expected few hundred cycles
    initial begin
        #200000;
        num_errors++;
        end_of_test;
    end
endmodule // spindle_command_decoder_tb
